/* File: msx_cfg.svh */
// Purpose: Offsets, reset values and fixed counts of the subtract/skip/table/xor datapath
// Assumes: Included by its bare name from the ALU, the core and the bench
// Notes: Definitions only
`ifndef MSX_CFG_SVH
`define MSX_CFG_SVH
// Register byte offsets on the APB
`define MSX_OFF_CMD 8'h00
`define MSX_OFF_ACC 8'h04
`define MSX_OFF_STAT 8'h08
`define MSX_OFF_TPTR 8'h0C
`define MSX_OFF_PAGE 8'h10
`define MSX_OFF_THI 8'h14
`define MSX_OFF_MADDR 8'h18
`define MSX_OFF_MDATA 8'h1C
`define MSX_OFF_PMADDR 8'h20
`define MSX_OFF_PMDATA 8'h24
`define MSX_OFF_EXEC 8'h28
// Field widths and reset values
`define MSX_CMD_W 23
`define MSX_PM_W 10
`define MSX_BYTE_RST 8'h00
`define MSX_STAT_RST 6'h00
`define MSX_PAGE_RST 2'h0
`define MSX_PM_RST 10'h000
`define MSX_LAST_PAGE 2'h3
`define MSX_WORD_ZERO 32'h0000_0000
// Carry-in of the two's complement subtract
`define MSX_ONE9 9'h001
`define MSX_ONE5 5'h01
// Cycle counts of one instruction
`define MSX_CYC_NONE 2'h0
`define MSX_CYC_ONE 2'h1
`define MSX_CYC_TWO 2'h2
`endif

/* File: msx_pkg.sv */
// Purpose: Types shared by the datapath modules
// Assumes: Nothing beyond the language
// Notes: Command layout is the low bits of a command write
package msx_pkg;
  typedef enum logic [3:0] {
    OP_SUB_ACC = 4'b0000,
    OP_MINUS_INTO_MEMORY = 4'b0001,
    OP_SUB_IMM = 4'b0010,
    OP_SWAP_MEM = 4'b0011,
    OP_NIBBLE_SWAP_TO_ACCUMULATOR = 4'b0100,
    OP_SKIP_IF_ZERO = 4'b0101,
    OP_LOAD_SKIP_IF_ZERO = 4'b0110,
    OP_SKIP_BIT_ZERO = 4'b0111,
    OP_TABLE_READ_CURRENT_PAGE = 4'b1000,
    OP_TABLE_READ_FINAL_PAGE = 4'b1001,
    OP_XOR_ACC = 4'b1010,
    OP_EXCLUSIVE_OR_INTO_MEMORY = 4'b1011,
    OP_XOR_IMM = 4'b1100
  } msx_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DUMMY = 2'b10
  } msx_state_type;

  typedef struct packed {
    logic watchdog_expiry_flag;
    logic power_down_flag;
    logic signed_wrap_flag;
    logic zero_flag;
    logic nibble_carry_flag;
    logic carry_flag;
  } msx_flags_type;

  typedef struct packed {
    logic [7:0] imm;
    logic [7:0] addr;
    logic [2:0] bsel;
    msx_op_type op;
  } msx_cmd_type;

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] thi;
    msx_flags_type flags;
    logic to_acc;
    logic to_mem;
    logic to_thi;
    logic skip;
    logic legal;
  } msx_res_type;
endpackage

/* File: msx_apb_port.sv */
// Purpose: APB access timing: one wait state, read capture and write take strobes
// Assumes: Master holds the request until pready is seen high
// Notes: Stall holds pready low while an instruction executes
`timescale 1ns/1ns
`default_nettype none
module msx_apb_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic stall,
  output logic pready,
  output logic take,
  output logic load
);
  // Capture cycle: read data and error are loaded here
  assign load = psel & penable & ~pready & ~stall;
  // Completing edge: writes take effect here
  assign take = psel & penable & pready;

  // Ready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= load;
    end
  end
endmodule
`default_nettype wire

/* File: msx_alu.sv */
// Purpose: Combinational result, flags and skip decision of one instruction
// Assumes: Operands are stable for the execute cycle
// Notes: Unknown opcodes change nothing
`timescale 1ns/1ns
`default_nettype none
`include "msx_cfg.svh"
module msx_alu (
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire logic [15:0] word,
  input wire msx_pkg::msx_cmd_type cmd,
  input wire msx_pkg::msx_flags_type flags,
  output msx_pkg::msx_res_type res
);
  import msx_pkg::*;

  // Subtract as a plus inverted b plus one
  function automatic msx_res_type sub_calc(input logic [7:0] a, input logic [7:0] b,
                                           input msx_flags_type f);
    logic [8:0] s;
    logic [4:0] n;
    msx_res_type r;
    s = {1'b0, a} + {1'b0, ~b} + `MSX_ONE9;
    n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + `MSX_ONE5;
    r = '0;
    r.value = s[7:0];
    r.flags = f;
    r.flags.carry_flag = s[8];
    r.flags.nibble_carry_flag = n[4];
    r.flags.signed_wrap_flag = (a[7] != b[7]) && (s[7] != a[7]);
    r.flags.zero_flag = (s[7:0] == `MSX_BYTE_RST);
    r.legal = 1'b1;
    return r;
  endfunction

  // Bitwise xor touching only the zero flag
  function automatic msx_res_type xor_calc(input logic [7:0] a, input logic [7:0] b,
                                           input msx_flags_type f);
    msx_res_type r;
    r = '0;
    r.value = a ^ b;
    r.flags = f;
    r.flags.zero_flag = ((a ^ b) == `MSX_BYTE_RST);
    r.legal = 1'b1;
    return r;
  endfunction

  // Result selection per opcode
  always_comb begin
    res = '0;
    res.flags = flags;
    res.legal = 1'b1;
    case (cmd.op)
      OP_SUB_ACC: begin
        res = sub_calc(acc, mem, flags);
        res.to_acc = 1'b1;
      end
      OP_MINUS_INTO_MEMORY: begin
        res = sub_calc(acc, mem, flags);
        res.to_mem = 1'b1;
      end
      OP_SUB_IMM: begin
        res = sub_calc(acc, cmd.imm, flags);
        res.to_acc = 1'b1;
      end
      OP_SWAP_MEM: begin
        res.value = {mem[3:0], mem[7:4]};
        res.to_mem = 1'b1;
      end
      OP_NIBBLE_SWAP_TO_ACCUMULATOR: begin
        res.value = {mem[3:0], mem[7:4]};
        res.to_acc = 1'b1;
      end
      OP_SKIP_IF_ZERO: res.skip = (mem == `MSX_BYTE_RST);
      OP_LOAD_SKIP_IF_ZERO: begin
        res.value = mem;
        res.to_acc = 1'b1;
        res.skip = (mem == `MSX_BYTE_RST);
      end
      OP_SKIP_BIT_ZERO: res.skip = ~mem[cmd.bsel];
      OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_FINAL_PAGE: begin
        res.value = word[7:0];
        res.thi = word[15:8];
        res.to_mem = 1'b1;
        res.to_thi = 1'b1;
      end
      OP_XOR_ACC: begin
        res = xor_calc(acc, mem, flags);
        res.to_acc = 1'b1;
      end
      OP_EXCLUSIVE_OR_INTO_MEMORY: begin
        res = xor_calc(acc, mem, flags);
        res.to_mem = 1'b1;
      end
      OP_XOR_IMM: begin
        res = xor_calc(acc, cmd.imm, flags);
        res.to_acc = 1'b1;
      end
      default: res.legal = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* File: msx_core.sv */
// Purpose: Execution datapath for subtract, swap, skip, table read and xor instructions
// Assumes: APB master per the AMBA protocol; one clock pclk
// Notes: A command write starts one instruction; other accesses wait while it runs
// Behaviour
// - Subtract from accumulator loads acc plus inverted byte plus one, updating four flags.
// - Subtract into memory writes acc plus inverted byte plus one back to the byte.
// - Subtract immediate keeps acc plus inverted immediate plus one in the accumulator.
// - Swap in memory exchanges the two nibbles of the byte and keeps all flags.
// - Swap to accumulator puts the swapped byte in the accumulator only, flags kept.
// - Byte skip test takes two cycles when the byte is zero, else one, flags kept.
// - Load and skip copies the byte to the accumulator and skips when it is zero.
// - Bit skip test takes two cycles when the chosen bit is zero, else one.
// - Current page table read puts the low byte in memory and the high in the latch.
// - Final page table read does the same from the last program page.
// - Xor with memory leaves the result in the accumulator, only zero flag changes.
// - Xor into memory writes the result to the byte, only zero flag changes.
// - Xor immediate leaves the result in the accumulator, only zero flag changes.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "msx_cfg.svh"
module msx_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy,
  output logic skip_dummy
);
  import msx_pkg::*;

  logic [7:0] dmem [256];
  logic [15:0] pmem [1024];
  logic [7:0] acc_r;
  msx_flags_type flags_r;
  logic [7:0] table_pointer_r;
  logic [1:0] page_r;
  logic [7:0] table_high_latch_r;
  logic [7:0] maddr_r;
  logic [`MSX_PM_W-1:0] pmaddr_r;
  msx_cmd_type cmd_r;
  msx_state_type state_r;
  msx_state_type state_nxt;
  logic [1:0] last_cyc_r;
  logic illegal_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic busy_r;
  logic skip_r;
  logic take;
  logic load;
  logic wr_en;
  logic exec;
  logic [7:0] mem_rd;
  logic [1:0] tpage;
  logic [15:0] word_rd;
  msx_res_type res;

  // Mapped offsets
  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      `MSX_OFF_CMD, `MSX_OFF_ACC, `MSX_OFF_STAT, `MSX_OFF_TPTR, `MSX_OFF_PAGE,
      `MSX_OFF_THI, `MSX_OFF_MADDR, `MSX_OFF_MDATA, `MSX_OFF_PMADDR,
      `MSX_OFF_PMDATA, `MSX_OFF_EXEC: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // Read data mux, unused bits as zero
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      `MSX_OFF_CMD: rd_mux = 32'(cmd_r);
      `MSX_OFF_ACC: rd_mux = 32'(acc_r);
      `MSX_OFF_STAT: rd_mux = 32'(flags_r);
      `MSX_OFF_TPTR: rd_mux = 32'(table_pointer_r);
      `MSX_OFF_PAGE: rd_mux = 32'(page_r);
      `MSX_OFF_THI: rd_mux = 32'(table_high_latch_r);
      `MSX_OFF_MADDR: rd_mux = 32'(maddr_r);
      `MSX_OFF_MDATA: rd_mux = 32'(dmem[maddr_r]);
      `MSX_OFF_PMADDR: rd_mux = 32'(pmaddr_r);
      `MSX_OFF_PMDATA: rd_mux = 32'(pmem[pmaddr_r]);
      `MSX_OFF_EXEC: rd_mux = 32'({illegal_r, last_cyc_r, skip_r, busy_r});
      default: rd_mux = `MSX_WORD_ZERO;
    endcase
  endfunction

  // Bus timing; accesses wait while an instruction runs
  msx_apb_port u_port (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .stall(state_r != ST_IDLE),
    .pready(pready),
    .take(take),
    .load(load)
  );

  assign wr_en = take & pwrite & addr_ok(paddr);
  assign exec = (state_r == ST_EXEC);
  assign mem_rd = dmem[cmd_r.addr];
  // Final page read ignores the current page
  assign tpage = (cmd_r.op == OP_TABLE_READ_FINAL_PAGE) ? `MSX_LAST_PAGE : page_r;
  assign word_rd = pmem[{tpage, table_pointer_r}];

  msx_alu u_alu (
    .acc(acc_r),
    .mem(mem_rd),
    .word(word_rd),
    .cmd(cmd_r),
    .flags(flags_r),
    .res(res)
  );

  // Sequencer: execute, then a dummy cycle when skipping
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (wr_en && paddr == `MSX_OFF_CMD) state_nxt = ST_EXEC;
      ST_EXEC: state_nxt = res.skip ? ST_DUMMY : ST_IDLE;
      ST_DUMMY: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
      skip_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt != ST_IDLE);
      skip_r <= (state_nxt == ST_DUMMY);
    end
  end

  // Cycle count and legality of the last instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cyc_r <= `MSX_CYC_NONE;
      illegal_r <= 1'b0;
    end else if (exec) begin
      last_cyc_r <= res.skip ? `MSX_CYC_TWO : `MSX_CYC_ONE;
      illegal_r <= ~res.legal;
    end
  end

  // Command latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= msx_cmd_type'(`MSX_CMD_W'(0));
    end else if (wr_en && paddr == `MSX_OFF_CMD) begin
      cmd_r <= msx_cmd_type'(pwdata[`MSX_CMD_W-1:0]);
    end
  end

  // Accumulator: software write or instruction result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= `MSX_BYTE_RST;
    end else if (exec && res.to_acc) begin
      acc_r <= res.value;
    end else if (wr_en && paddr == `MSX_OFF_ACC) begin
      acc_r <= pwdata[7:0];
    end
  end

  // Status flags; ops other than subtract and xor pass them through unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= msx_flags_type'(`MSX_STAT_RST);
    end else if (exec) begin
      flags_r <= res.flags;
    end else if (wr_en && paddr == `MSX_OFF_STAT) begin
      flags_r <= msx_flags_type'(pwdata[5:0]);
    end
  end

  // Table pointer, page and high latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_pointer_r <= `MSX_BYTE_RST;
      page_r <= `MSX_PAGE_RST;
      table_high_latch_r <= `MSX_BYTE_RST;
    end else begin
      if (wr_en && paddr == `MSX_OFF_TPTR) table_pointer_r <= pwdata[7:0];
      if (wr_en && paddr == `MSX_OFF_PAGE) page_r <= pwdata[1:0];
      if (exec && res.to_thi) table_high_latch_r <= res.thi;
    end
  end

  // Memory window address registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maddr_r <= `MSX_BYTE_RST;
      pmaddr_r <= `MSX_PM_RST;
    end else begin
      if (wr_en && paddr == `MSX_OFF_MADDR) maddr_r <= pwdata[7:0];
      if (wr_en && paddr == `MSX_OFF_PMADDR) pmaddr_r <= pwdata[`MSX_PM_W-1:0];
    end
  end

  // Data memory: instruction write-back or software window
  always_ff @(posedge pclk) begin
    if (exec && res.to_mem) begin
      dmem[cmd_r.addr] <= res.value;
    end else if (wr_en && paddr == `MSX_OFF_MDATA) begin
      dmem[maddr_r] <= pwdata[7:0];
    end
  end

  // Program memory loaded by software
  always_ff @(posedge pclk) begin
    if (wr_en && paddr == `MSX_OFF_PMDATA) pmem[pmaddr_r] <= pwdata[15:0];
  end

  // Read data and error captured one cycle before completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= `MSX_WORD_ZERO;
      pslverr_r <= 1'b0;
    end else if (load) begin
      prdata_r <= pwrite ? `MSX_WORD_ZERO : rd_mux(paddr);
      pslverr_r <= ~addr_ok(paddr);
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign busy = busy_r;
  assign skip_dummy = skip_r;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sub_acc_a: assert property (exec && cmd_r.op == OP_SUB_ACC |=>
    acc_r == 8'($past(acc_r) - $past(mem_rd)) &&
    flags_r.watchdog_expiry_flag == $past(flags_r.watchdog_expiry_flag) &&
    flags_r.power_down_flag == $past(flags_r.power_down_flag))
    else $error("subtract to accumulator wrong");
  sub_flags_a: assert property (exec && cmd_r.op == OP_SUB_ACC |=>
    flags_r.carry_flag == ($past(acc_r) >= $past(mem_rd)) &&
    flags_r.zero_flag == ($past(acc_r) == $past(mem_rd)))
    else $error("subtract carry or zero wrong");
  sub_mem_a: assert property (exec && cmd_r.op == OP_MINUS_INTO_MEMORY |=>
    dmem[$past(cmd_r.addr)] == 8'($past(acc_r) - $past(mem_rd)) && $stable(acc_r))
    else $error("subtract into memory wrong");
  sub_imm_a: assert property (exec && cmd_r.op == OP_SUB_IMM |=>
    acc_r == 8'($past(acc_r) - $past(cmd_r.imm)))
    else $error("subtract immediate wrong");
  swap_mem_a: assert property (exec && cmd_r.op == OP_SWAP_MEM |=>
    dmem[$past(cmd_r.addr)] == {$past(mem_rd[3:0]), $past(mem_rd[7:4])} && $stable(flags_r))
    else $error("memory swap wrong");
  swap_acc_a: assert property (exec && cmd_r.op == OP_NIBBLE_SWAP_TO_ACCUMULATOR |=>
    acc_r == {$past(mem_rd[3:0]), $past(mem_rd[7:4])} && $stable(flags_r) &&
    dmem[$past(cmd_r.addr)] == $past(mem_rd))
    else $error("accumulator swap wrong");
  skip_byte_a: assert property (exec && cmd_r.op == OP_SKIP_IF_ZERO |=>
    if ($past(mem_rd) == `MSX_BYTE_RST) (state_r == ST_DUMMY ##1 state_r == ST_IDLE)
    else (state_r == ST_IDLE && last_cyc_r == `MSX_CYC_ONE))
    else $error("byte skip timing wrong");
  load_skip_a: assert property (exec && cmd_r.op == OP_LOAD_SKIP_IF_ZERO |=>
    acc_r == $past(mem_rd) && $stable(flags_r) &&
    skip_dummy == ($past(mem_rd) == `MSX_BYTE_RST))
    else $error("load and skip wrong");
  skip_bit_a: assert property (exec && cmd_r.op == OP_SKIP_BIT_ZERO |=>
    skip_dummy == !$past(mem_rd[cmd_r.bsel]) && $stable(flags_r))
    else $error("bit skip wrong");
  table_cur_a: assert property (exec && cmd_r.op == OP_TABLE_READ_CURRENT_PAGE |=>
    table_high_latch_r == $past(pmem[{page_r, table_pointer_r}][15:8]) &&
    dmem[$past(cmd_r.addr)] == $past(pmem[{page_r, table_pointer_r}][7:0]))
    else $error("current page table read wrong");
  table_last_a: assert property (exec && cmd_r.op == OP_TABLE_READ_FINAL_PAGE |=>
    table_high_latch_r == $past(pmem[{`MSX_LAST_PAGE, table_pointer_r}][15:8]) &&
    $stable(flags_r))
    else $error("final page table read wrong");
  xor_acc_a: assert property (exec && cmd_r.op == OP_XOR_ACC |=>
    acc_r == ($past(acc_r) ^ $past(mem_rd)) && $stable(flags_r.carry_flag) &&
    $stable(flags_r.signed_wrap_flag) && flags_r.zero_flag == (acc_r == `MSX_BYTE_RST))
    else $error("xor to accumulator wrong");
  xor_mem_a: assert property (exec && cmd_r.op == OP_EXCLUSIVE_OR_INTO_MEMORY |=>
    dmem[$past(cmd_r.addr)] == ($past(acc_r) ^ $past(mem_rd)) &&
    $stable(flags_r.nibble_carry_flag))
    else $error("xor into memory wrong");
  xor_imm_a: assert property (exec && cmd_r.op == OP_XOR_IMM |=>
    acc_r == ($past(acc_r) ^ $past(cmd_r.imm)) && $stable(flags_r.carry_flag))
    else $error("xor immediate wrong");

  skip_taken_c: cover property (exec ##1 state_r == ST_DUMMY);
  table_read_c: cover property (exec && cmd_r.op == OP_TABLE_READ_FINAL_PAGE);
  wait_bus_c: cover property (psel && penable && busy_r);
endmodule
`default_nettype wire

/* File: tb_msx_core.sv */
// Purpose: Self-checking bench for the msx_core datapath, driven over APB
// Assumes: One clock pclk, reset held for three cycles
// Notes: Every transfer queues its expected answer; a monitor compares in order
`timescale 1ns/1ns
`default_nettype none
`include "msx_cfg.svh"
module tb_msx_core;
  import msx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, busy, skip_dummy;
  logic [32:0] exp_q[$];
  int cyc_q[$];
  int error_cnt = 0;
  int checks_done = 0;
  int run = 0;

  msx_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .skip_dummy(skip_dummy));

  // Free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Compare one seen value with one expectation
  task check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Report the counts and the verdict, then stop
  task end_of_test;
    $display("Mismatches %0d, comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; holds the request until pready, then idles one cycle
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      error_cnt++;
      $display("Error at %0t: no ready on the bus", $time);
      end_of_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, {1'b0, e});
  endtask

  task put_mem(input logic [7:0] a, input logic [7:0] d);
    wr(`MSX_OFF_MADDR, {24'h0, a});
    wr(`MSX_OFF_MDATA, {24'h0, d});
  endtask

  task see_mem(input logic [7:0] a, input logic [7:0] e);
    wr(`MSX_OFF_MADDR, {24'h0, a});
    rd(`MSX_OFF_MDATA, {24'h0, e});
  endtask

  // Start one instruction and note how many busy cycles it must take
  task run_op(input msx_op_type op, input logic [2:0] b, input logic [7:0] m,
              input logic [7:0] imm, input int cyc);
    msx_cmd_type c;
    c = '{imm: imm, addr: m, bsel: b, op: op};
    cyc_q.push_back(cyc);
    wr(`MSX_OFF_CMD, {9'h0, c});
  endtask

  // Bench model of the subtract flags
  function automatic msx_flags_type sub_flags(input logic [7:0] a, input logic [7:0] m,
                                              input msx_flags_type f);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, ~m} + 9'h001;
    h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + 5'h01;
    f.signed_wrap_flag = (a[7] != m[7]) && (s[7] != a[7]);
    f.zero_flag = (s[7:0] == 8'h00);
    f.nibble_carry_flag = h[4];
    f.carry_flag = s[8];
    return f;
  endfunction

  // Monitor: answers against queued notes, busy run lengths against cycle notes
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
    if (busy === 1'b1) begin
      check(33'(skip_dummy), 33'(run > 0));
      run++;
    end else if (run > 0) begin
      check(33'(run), 33'(cyc_q.pop_front()));
      run = 0;
    end
  end

  // Hang guard
  initial begin
    #500000;
    error_cnt++;
    $display("Error at %0t: run timed out", $time);
    end_of_test;
  end

  // Main sequence
  initial begin
    logic [7:0] a, m, r, s, t, ad;
    logic [15:0] w;
    logic [2:0] b;
    msx_flags_type f, g;
    int i;
    void'($urandom(32'h2C39));
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset state, unmapped places and the read-only latch
    rd(`MSX_OFF_ACC, 32'h0);
    rd(`MSX_OFF_STAT, 32'h0);
    rd(`MSX_OFF_THI, 32'h0);
    xfer(1'b0, 8'h2C, 32'h0, {1'b1, 32'h0});
    xfer(1'b1, 8'h30, 32'hFF, {1'b1, 32'h0});
    wr(`MSX_OFF_THI, 32'hFF);
    rd(`MSX_OFF_THI, 32'h0);
    // Subtract forms: boundary operands first, then random ones
    for (i = 0; i < 9; i++) begin
      a = 8'($urandom);
      m = 8'($urandom);
      f = msx_flags_type'(6'($urandom));
      if (i == 0) begin a = 8'h5A; m = 8'h5A; end
      if (i == 1) begin a = 8'h80; m = 8'h01; end
      if (i == 2) begin a = 8'h00; m = 8'h01; end
      ad = 8'h10 + 8'(i);
      r = a + ~m + 8'h01;
      wr(`MSX_OFF_ACC, {24'h0, a});
      wr(`MSX_OFF_STAT, {26'h0, f});
      put_mem(ad, m);
      case (i % 3)
        0: begin
          run_op(OP_SUB_ACC, 3'h0, ad, 8'h00, 1);
          rd(`MSX_OFF_ACC, {24'h0, r});
          see_mem(ad, m);
        end
        1: begin
          run_op(OP_MINUS_INTO_MEMORY, 3'h0, ad, 8'h00, 1);
          rd(`MSX_OFF_ACC, {24'h0, a});
          see_mem(ad, r);
        end
        default: begin
          run_op(OP_SUB_IMM, 3'h0, 8'hFF, m, 1);
          rd(`MSX_OFF_ACC, {24'h0, r});
        end
      endcase
      rd(`MSX_OFF_STAT, {26'h0, sub_flags(a, m, f)});
    end
    // Swap, skip, xor and table reads, zero byte in the first round
    for (i = 0; i < 4; i++) begin
      m = (i == 0) ? 8'h00 : 8'($urandom);
      a = 8'($urandom);
      t = 8'($urandom);
      w = 16'($urandom);
      b = 3'(i * 3);
      f = msx_flags_type'(6'($urandom));
      s = {m[3:0], m[7:4]};
      wr(`MSX_OFF_ACC, {24'h0, a});
      wr(`MSX_OFF_STAT, {26'h0, f});
      put_mem(8'h20, m);
      run_op(OP_SWAP_MEM, 3'h0, 8'h20, 8'h00, 1);
      see_mem(8'h20, s);
      run_op(OP_NIBBLE_SWAP_TO_ACCUMULATOR, 3'h0, 8'h20, 8'h00, 1);
      rd(`MSX_OFF_ACC, {24'h0, m});
      see_mem(8'h20, s);
      run_op(OP_SKIP_IF_ZERO, 3'h0, 8'h20, 8'h00, (s == 8'h00) ? 2 : 1);
      run_op(OP_SKIP_BIT_ZERO, b, 8'h20, 8'h00, s[b] ? 1 : 2);
      rd(`MSX_OFF_EXEC, {28'h0, s[b] ? 2'h1 : 2'h2, 2'h0});
      run_op(OP_LOAD_SKIP_IF_ZERO, 3'h0, 8'h20, 8'h00, (s == 8'h00) ? 2 : 1);
      rd(`MSX_OFF_ACC, {24'h0, s});
      rd(`MSX_OFF_STAT, {26'h0, f});
      wr(`MSX_OFF_ACC, {24'h0, a});
      r = a ^ s;
      run_op(OP_XOR_ACC, 3'h0, 8'h20, 8'h00, 1);
      rd(`MSX_OFF_ACC, {24'h0, r});
      g = f;
      g.zero_flag = (r == 8'h00);
      rd(`MSX_OFF_STAT, {26'h0, g});
      run_op(OP_EXCLUSIVE_OR_INTO_MEMORY, 3'h0, 8'h20, 8'h00, 1);
      see_mem(8'h20, a);
      g.zero_flag = (a == 8'h00);
      rd(`MSX_OFF_STAT, {26'h0, g});
      run_op(OP_XOR_IMM, 3'h0, 8'h20, a, 1);
      rd(`MSX_OFF_ACC, {24'h0, s});
      g.zero_flag = (s == 8'h00);
      wr(`MSX_OFF_PMADDR, {22'h0, 2'(i % 3), t});
      wr(`MSX_OFF_PMDATA, {16'h0, w});
      wr(`MSX_OFF_PMADDR, {22'h0, `MSX_LAST_PAGE, t});
      wr(`MSX_OFF_PMDATA, {16'h0, ~w});
      wr(`MSX_OFF_TPTR, {24'h0, t});
      wr(`MSX_OFF_PAGE, {30'h0, 2'(i % 3)});
      run_op(OP_TABLE_READ_CURRENT_PAGE, 3'h0, 8'h21, 8'h00, 1);
      see_mem(8'h21, w[7:0]);
      rd(`MSX_OFF_THI, {24'h0, w[15:8]});
      run_op(OP_TABLE_READ_FINAL_PAGE, 3'h0, 8'h22, 8'h00, 1);
      see_mem(8'h22, ~w[7:0]);
      rd(`MSX_OFF_THI, {24'h0, ~w[15:8]});
      rd(`MSX_OFF_STAT, {26'h0, g});
    end
    // Unknown opcode: one cycle, illegal bit set, nothing else touched
    run_op(msx_op_type'(4'hD), 3'h0, 8'h20, 8'h00, 1);
    rd(`MSX_OFF_EXEC, 32'h0000_0014);
    rd(`MSX_OFF_ACC, {24'h0, s});
    rd(`MSX_OFF_STAT, {26'h0, g});
    see_mem(8'h20, a);
    end_of_test;
  end
endmodule
`default_nettype wire
